/* File: logic/cdsd_pkg.sv */
/*
  Shared constants for the complementary drive block: register map,
  field positions, reset values, source and override codes, FSM states.
  Assumes a 40 MHz system clock and a 32-bit APB register bus.
*/
`default_nettype none
package cdsd_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DB_W = 6;
  localparam int SRC_W = 3;
  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL_MAIN = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_OVR_SRC = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_SD_CTRL = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_RISE_DB = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_FALL_DB = 8'h10;
  // waveform_control_main fields
  localparam int BIT_MODULE_ON = 7;
  localparam int BIT_B_ROUTE = 6;
  localparam int BIT_A_ROUTE = 5;
  localparam int BIT_B_INV = 4;
  localparam int BIT_A_INV = 3;
  localparam int BIT_CLK_SEL = 0;
  // waveform_override_and_source fields
  localparam int OVR_B_LSB = 6;
  localparam int OVR_A_LSB = 4;
  localparam int SRC_LSB = 0;
  // waveform_shutdown_control fields
  localparam int BIT_SD_EVENT = 7;
  localparam int BIT_AUTO = 6;
  localparam int BIT_CMP_SD = 2;
  localparam int BIT_FLT_SD = 1;
  // Reset values and writable masks
  localparam logic [7:0] RST_CTRL_MAIN = 8'h00;
  localparam logic [7:0] RST_OVR_SRC = 8'h00;
  localparam logic [7:0] RST_SD_CTRL = 8'h00;
  localparam logic [DB_W-1:0] RST_DB = 6'h00;
  localparam logic [7:0] MASK_CTRL_MAIN = 8'hf9;
  localparam logic [7:0] MASK_OVR_SRC = 8'hf7;
  localparam logic [7:0] MASK_SD_CTRL = 8'h46;
  // Input source codes
  localparam logic [SRC_W-1:0] SRC_CMP = 3'h0;
  localparam logic [SRC_W-1:0] SRC_PWM1 = 3'h2;
  localparam logic [SRC_W-1:0] SRC_PWM2 = 3'h3;
  localparam logic [SRC_W-1:0] SRC_PWM3 = 3'h4;
  // Override level codes
  localparam logic [1:0] OVR_INACTIVE = 2'h0;
  localparam logic [1:0] OVR_TRI = 2'h1;
  localparam logic [1:0] OVR_LOW = 2'h2;
  localparam logic [1:0] OVR_HIGH = 2'h3;
  // Generator clock rates in MHz
  localparam logic [5:0] SYS_CLK_MHZ = 6'h28;
  localparam logic [5:0] HF_OSC_MHZ = 6'h10;

  typedef enum logic [2:0] {WV_IDLE, WV_RISE_DB, WV_A_ON, WV_FALL_DB, WV_B_ON} cdsd_wave_t;

  function automatic logic cdsd_ovr_level(input logic [1:0] code, input logic inv);
    logic lvl;
    lvl = inv;
    if (code == OVR_HIGH) lvl = 1'b1;
    else if (code == OVR_LOW) lvl = 1'b0;
    return lvl;
  endfunction : cdsd_ovr_level

  function automatic logic cdsd_mapped(input logic [ADDR_W-1:0] a);
    return (a == ADDR_CTRL_MAIN) || (a == ADDR_OVR_SRC) || (a == ADDR_SD_CTRL) ||
           (a == ADDR_RISE_DB) || (a == ADDR_FALL_DB);
  endfunction : cdsd_mapped
endpackage : cdsd_pkg
`default_nettype wire

/* File: logic/cdsd_db_if.sv */
/*
  Link between the waveform FSM and one dead-band timer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface cdsd_db_if;
  logic start;
  logic abort;
  logic tick;
  logic [cdsd_pkg::DB_W-1:0] limit;
  logic done;
  modport ctl (output start, output abort, output tick, output limit, input done);
  modport tmr (input start, input abort, input tick, input limit, output done);
endinterface : cdsd_db_if
`default_nettype wire

/* File: logic/cdsd_deadband.sv */
/*
  One 6-bit dead-band timer counting generator ticks from zero to a limit.
  Assumes start is a single-cycle strobe from the FSM; abort stays high while the module is off or shut down.
*/
`timescale 1ns/1ps
`default_nettype none
module cdsd_deadband (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Control link
  cdsd_db_if.tmr db
);
  import cdsd_pkg::*;
  logic [DB_W-1:0] cnt_q, cnt_d;
  logic run_q, run_d;

  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    if (db.abort) begin
      run_d = 1'b0;
    end else if (db.start) begin
      run_d = 1'b1;
      cnt_d = '0;
    end else if (run_q && (cnt_q == db.limit)) begin
      run_d = 1'b0;
    end else if (run_q && db.tick) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end

  // Limit zero means no dead band: done the cycle after start
  assign db.done = run_q && (cnt_q == db.limit);
endmodule : cdsd_deadband
`default_nettype wire

/* File: logic/cdsd_shutdown.sv */
/*
  Shutdown event flag and override hold.
  Assumes i_ext_act is the raw, unsynchronised enabled-source request.
*/
`timescale 1ns/1ps
`default_nettype none
module cdsd_shutdown (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Software access to the event bit
  input wire logic i_wr_event,
  input wire logic i_wr_value,
  input wire logic i_auto_restart_on,
  // Sources and waveform
  input wire logic i_ext_act,
  input wire logic i_rise_edge,
  // State
  output logic o_shutdown_event,
  output logic o_hold
);
  logic event_q, event_d;
  logic hold_q, hold_d;

  always_comb begin
    event_d = event_q;
    if ((i_wr_event && i_wr_value) || i_ext_act) begin
      event_d = 1'b1;
    end else if (i_auto_restart_on) begin
      event_d = 1'b0;
    end else if (i_wr_event && !i_wr_value) begin
      event_d = 1'b0;
    end
    hold_d = hold_q;
    if (event_q || i_ext_act) begin
      hold_d = 1'b1;
    end else if (i_rise_edge) begin
      hold_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      event_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      event_q <= event_d;
      hold_q <= hold_d;
    end
  end

  assign o_shutdown_event = event_q;
  assign o_hold = hold_q;
endmodule : cdsd_shutdown
`default_nettype wire

/* File: logic/cdsd_top.sv */
/*
  Complementary drive generator with dead band and auto-shutdown,
  APB register slave, two drive pins with output enables.
  Assumes PWM inputs on i_clk; comparator and fault pins asynchronous.
*/
//
// Notes on behaviour
// - Writing one to shutdown_event forces shutdown; outputs take override levels.
// - Without auto restart, software shutdown holds while shutdown_event stays set.
// - With auto restart, shutdown_event self-clears; waveform resumes next rising edge.
// - Any enabled external source forces override levels without software delay.
// - Sources are levels; shutdown holds while an enabled source stays active.
// - Comparator high causes shutdown only when comparator_shutdown_on (bit 2) set.
// - Fault pin low causes shutdown only when fault_shutdown_on (bit 1) set.
// - Override codes: 11 high, 10 low, 01 tri-state, 00 inactive with polarity.
// - Override field B sits at bits 7:6, A at bits 5:4.
// - Software clear of shutdown_event fails while any enabled source is active.
// - Auto restart clears shutdown_event once all enabled sources go inactive.
// - Overrides persist until first rising input edge after shutdown_event clears.
// - shutdown_event reads at bit 7; auto_restart_on at bit 6 selects auto restart.
// - module_on at bit 7 turns the generator on or off.
// - Bits 6 and 5 route outputs B and A to their pins.
// - Bits 4 and 3 invert outputs B and A.
// - Bit 0 selects internal oscillator rate (one) or system clock (zero).
// - Source codes 100, 011, 010 pick PWM3, PWM2, PWM1; 000 comparator.
// - Generator keeps running in sleep; nothing here gates on sleep.
// - Rising edge: B off at once, A on after rising dead band.
// - Falling edge: A off at once, B on after falling dead band.
// - Each dead band is a 6-bit counter of generator ticks.
// - Turning the module on starts with both drives cleared.
`timescale 1ns/1ps
`default_nettype none
module cdsd_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [cdsd_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [cdsd_pkg::DATA_W-1:0] i_pwdata,
  output logic [cdsd_pkg::DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Waveform and shutdown sources
  input wire logic [2:0] i_pwm_outs,
  input wire logic i_comparator_async_out,
  input wire logic i_fault_input_n,
  // Drive pins
  output logic o_drive_output_a,
  output logic o_drive_output_a_oe,
  output logic o_drive_output_b,
  output logic o_drive_output_b_oe
);
  import cdsd_pkg::*;

  logic cmp_s1_q, cmp_s2_q;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [DATA_W-1:0] prdata_q, prdata_d;
  logic [7:0] ctrl_q, ctrl_d, ovr_q, ovr_d, sdc_q, sdc_d;
  logic [DB_W-1:0] dbr_q, dbr_d, dbf_q, dbf_d;
  logic wr_acc, wr_event, shutdown_event, hold, ext_act, shut_now, fsm_shut;
  logic src, src_q, rise_edge, fall_edge;
  logic [5:0] acc_q, acc_d;
  logic tick_q, tick_d;
  cdsd_wave_t wave_q, wave_d;
  logic drv_a_q, drv_a_d, oe_a_q, oe_a_d, drv_b_q, drv_b_d, oe_b_q, oe_b_d;
  logic module_on, route_a, route_b, inv_a, inv_b, clk_sel, auto_on, cmp_on, flt_on;
  logic [1:0] ovr_a, ovr_b;
  cdsd_db_if rdb ();
  cdsd_db_if fdb ();
  // Comparator feeds the waveform source select through this synchroniser; the shutdown trip to the FSM takes the raw pin
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
    end else begin
      cmp_s1_q <= i_comparator_async_out;
      cmp_s2_q <= cmp_s1_q;
    end
  end
  assign module_on = ctrl_q[BIT_MODULE_ON];
  assign route_b = ctrl_q[BIT_B_ROUTE];
  assign route_a = ctrl_q[BIT_A_ROUTE];
  assign inv_b = ctrl_q[BIT_B_INV];
  assign inv_a = ctrl_q[BIT_A_INV];
  assign clk_sel = ctrl_q[BIT_CLK_SEL];
  assign ovr_b = ovr_q[OVR_B_LSB +: 2];
  assign ovr_a = ovr_q[OVR_A_LSB +: 2];
  assign auto_on = sdc_q[BIT_AUTO];
  assign cmp_on = sdc_q[BIT_CMP_SD];
  assign flt_on = sdc_q[BIT_FLT_SD];
  // Raw pins on purpose: a synchroniser would delay the trip
  assign ext_act = (cmp_on & i_comparator_async_out)
                 | (flt_on & ~i_fault_input_n);
  assign shut_now = shutdown_event | ext_act;
  // Hold yields at the rising edge itself, so pins and FSM resume together
  assign fsm_shut = shut_now | (hold & ~rise_edge);
  // APB slave: one wait state, answer registered
  assign wr_acc = i_psel & i_penable & pready_q & i_pwrite;
  assign wr_event = wr_acc && (i_paddr == ADDR_SD_CTRL);
  always_comb begin
    pready_d = i_psel & i_penable & ~pready_q;
    pslverr_d = 1'b0;
    prdata_d = '0;
    ctrl_d = ctrl_q;
    ovr_d = ovr_q;
    sdc_d = sdc_q;
    dbr_d = dbr_q;
    dbf_d = dbf_q;
    if (pready_d) begin
      pslverr_d = ~cdsd_mapped(i_paddr);
    end
    if (pready_d && !i_pwrite) begin
      if (i_paddr == ADDR_CTRL_MAIN) begin
        prdata_d[7:0] = ctrl_q;
      end else if (i_paddr == ADDR_OVR_SRC) begin
        prdata_d[7:0] = ovr_q;
      end else if (i_paddr == ADDR_SD_CTRL) begin
        prdata_d[7:0] = sdc_q;
        prdata_d[BIT_SD_EVENT] = shutdown_event;
      end else if (i_paddr == ADDR_RISE_DB) begin
        prdata_d[DB_W-1:0] = dbr_q;
      end else if (i_paddr == ADDR_FALL_DB) begin
        prdata_d[DB_W-1:0] = dbf_q;
      end
    end
    if (wr_acc) begin
      if (i_paddr == ADDR_CTRL_MAIN) begin
        ctrl_d = i_pwdata[7:0] & MASK_CTRL_MAIN;
      end else if (i_paddr == ADDR_OVR_SRC) begin
        ovr_d = i_pwdata[7:0] & MASK_OVR_SRC;
      end else if (i_paddr == ADDR_SD_CTRL) begin
        sdc_d = i_pwdata[7:0] & MASK_SD_CTRL;
      end else if (i_paddr == ADDR_RISE_DB) begin
        dbr_d = i_pwdata[DB_W-1:0];
      end else if (i_paddr == ADDR_FALL_DB) begin
        dbf_d = i_pwdata[DB_W-1:0];
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      ctrl_q <= RST_CTRL_MAIN;
      ovr_q <= RST_OVR_SRC;
      sdc_q <= RST_SD_CTRL;
      dbr_q <= RST_DB;
      dbf_q <= RST_DB;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      ctrl_q <= ctrl_d;
      ovr_q <= ovr_d;
      sdc_q <= sdc_d;
      dbr_q <= dbr_d;
      dbf_q <= dbf_d;
    end
  end
  cdsd_shutdown u_shutdown (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_wr_event(wr_event),
    .i_wr_value(i_pwdata[BIT_SD_EVENT]),
    .i_auto_restart_on(auto_on),
    .i_ext_act(ext_act),
    .i_rise_edge(rise_edge),
    .o_shutdown_event(shutdown_event),
    .o_hold(hold)
  );
  // Source select; reserved codes give a quiet low input
  always_comb begin
    case (ovr_q[SRC_LSB +: SRC_W])
      SRC_CMP: src = cmp_s2_q;
      SRC_PWM1: src = i_pwm_outs[0];
      SRC_PWM2: src = i_pwm_outs[1];
      SRC_PWM3: src = i_pwm_outs[2];
      default: src = 1'b0;
    endcase
  end
  assign rise_edge = src & ~src_q;
  assign fall_edge = ~src & src_q;
  // Generator tick: every cycle, or a 16 MHz average by phase accumulation.
  // Independent of any sleep state, so it runs whenever i_clk runs.
  always_comb begin
    acc_d = acc_q;
    tick_d = 1'b1;
    if (clk_sel) begin
      if (acc_q + HF_OSC_MHZ >= SYS_CLK_MHZ) begin
        acc_d = acc_q + HF_OSC_MHZ - SYS_CLK_MHZ;
        tick_d = 1'b1;
      end else begin
        acc_d = acc_q + HF_OSC_MHZ;
        tick_d = 1'b0;
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      acc_q <= '0;
      tick_q <= 1'b0;
      src_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      tick_q <= tick_d;
      src_q <= src;
    end
  end
  cdsd_deadband u_rise_db (.i_clk(i_clk), .i_resetn(i_resetn), .db(rdb));
  cdsd_deadband u_fall_db (.i_clk(i_clk), .i_resetn(i_resetn), .db(fdb));
  assign rdb.tick = tick_q;
  assign fdb.tick = tick_q;
  assign rdb.limit = dbr_q;
  assign fdb.limit = dbf_q;
  // Waveform FSM; a short pulse aborts the pending dead band
  always_comb begin
    wave_d = wave_q;
    rdb.start = 1'b0;
    rdb.abort = 1'b0;
    fdb.start = 1'b0;
    fdb.abort = 1'b0;
    if (!module_on || fsm_shut) begin
      wave_d = WV_IDLE;
      rdb.abort = 1'b1;
      fdb.abort = 1'b1;
    end else if (rise_edge) begin
      wave_d = WV_RISE_DB;
      rdb.start = 1'b1;
      fdb.abort = 1'b1;
    end else if (fall_edge) begin
      wave_d = WV_FALL_DB;
      fdb.start = 1'b1;
      rdb.abort = 1'b1;
    end else begin
      case (wave_q)
        WV_RISE_DB: if (rdb.done) wave_d = WV_A_ON;
        WV_FALL_DB: if (fdb.done) wave_d = WV_B_ON;
        default: wave_d = wave_q;
      endcase
    end
  end
  // Pin stage; override path reacts in the cycle the request appears
  always_comb begin
    drv_a_d = 1'b0;
    drv_b_d = 1'b0;
    oe_a_d = 1'b0;
    oe_b_d = 1'b0;
    if (module_on) begin
      oe_a_d = route_a;
      oe_b_d = route_b;
      if (fsm_shut) begin
        drv_a_d = cdsd_ovr_level(ovr_a, inv_a);
        drv_b_d = cdsd_ovr_level(ovr_b, inv_b);
        oe_a_d = route_a & (ovr_a != OVR_TRI);
        oe_b_d = route_b & (ovr_b != OVR_TRI);
      end else begin
        drv_a_d = (wave_d == WV_A_ON) ^ inv_a;
        drv_b_d = (wave_d == WV_B_ON) ^ inv_b;
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wave_q <= WV_IDLE;
      drv_a_q <= 1'b0;
      drv_b_q <= 1'b0;
      oe_a_q <= 1'b0;
      oe_b_q <= 1'b0;
    end else begin
      wave_q <= wave_d;
      drv_a_q <= drv_a_d;
      drv_b_q <= drv_b_d;
      oe_a_q <= oe_a_d;
      oe_b_q <= oe_b_d;
    end
  end
  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_drive_output_a = drv_a_q;
  assign o_drive_output_a_oe = oe_a_q;
  assign o_drive_output_b = drv_b_q;
  assign o_drive_output_b_oe = oe_b_q;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  property p_sw_force;
    wr_event && i_pwdata[BIT_SD_EVENT] |=> shutdown_event;
  endproperty
  a_sw_force: assert property (p_sw_force)
    else $error("software shutdown not taken");
  property p_sw_hold;
    shutdown_event && !auto_on && !wr_event |=> shutdown_event;
  endproperty
  a_sw_hold: assert property (p_sw_hold)
    else $error("shutdown event dropped without restart");
  property p_auto_clear;
    shutdown_event && auto_on && !ext_act && !wr_event |=> !shutdown_event;
  endproperty
  a_auto_clear: assert property (p_auto_clear)
    else $error("auto restart did not clear event");
  property p_trip;
    module_on && route_a && ext_act && (ovr_a == OVR_HIGH)
      |=> o_drive_output_a && o_drive_output_a_oe;
  endproperty
  a_trip: assert property (p_trip)
    else $error("external trip did not reach pin A next cycle");
  property p_level_hold;
    ext_act ##1 ext_act |-> shutdown_event;
  endproperty
  a_level_hold: assert property (p_level_hold)
    else $error("event clear while source active");
  property p_cmp_trip;
    cmp_on && i_comparator_async_out |=> shutdown_event && hold;
  endproperty
  a_cmp_trip: assert property (p_cmp_trip)
    else $error("comparator trip missed");
  property p_flt_trip;
    flt_on && !i_fault_input_n |=> shutdown_event && hold;
  endproperty
  a_flt_trip: assert property (p_flt_trip)
    else $error("fault pin trip missed");
  property p_tristate;
    module_on && fsm_shut && (ovr_b == OVR_TRI) |=> !o_drive_output_b_oe;
  endproperty
  a_tristate: assert property (p_tristate)
    else $error("tri-state override still drives B");
  property p_clear_refused;
    wr_event && !i_pwdata[BIT_SD_EVENT] && ext_act |=> shutdown_event;
  endproperty
  a_clear_refused: assert property (p_clear_refused)
    else $error("clear accepted with source active");
  property p_override_persist;
    hold && !rise_edge |=> hold;
  endproperty
  a_override_persist: assert property (p_override_persist)
    else $error("override released without rising edge");
  property p_off_quiet;
    !module_on |=> !o_drive_output_a_oe && !o_drive_output_b_oe && (wave_q == WV_IDLE);
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("pins driven while module off");
  property p_rise_b_off;
    module_on && !fsm_shut && rise_edge && !inv_b |=> !o_drive_output_b;
  endproperty
  a_rise_b_off: assert property (p_rise_b_off)
    else $error("B not off after rising edge");
  property p_no_dead_zero;
    (wave_q == WV_RISE_DB) && rdb.done && module_on && !fsm_shut && !rise_edge
      && !fall_edge |=> (wave_q == WV_A_ON);
  endproperty
  a_no_dead_zero: assert property (p_no_dead_zero)
    else $error("A not on after rising dead band");
  property p_start_clear;
    $rose(module_on) |-> (wave_q == WV_IDLE);
  endproperty
  a_start_clear: assert property (p_start_clear)
    else $error("module started with a drive active");
endmodule : cdsd_top
`default_nettype wire

/* File: dv/cdsd_switch_model.sv */
/*
  Power switch pair fed by the two drive pins; counts cycles with both on.
  Assumes a high pin level turns a switch on; a released pin is pulled low.
*/
`timescale 1ns/1ps
`default_nettype none
module cdsd_switch_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Drive pins
  input wire logic i_a,
  input wire logic i_a_oe,
  input wire logic i_b,
  input wire logic i_b_oe,
  // Switch state
  output logic o_gate_a,
  output logic o_gate_b,
  output logic [15:0] o_overlap
);
  // Released pin sinks to the gate pull-down, never keeps the last level
  assign o_gate_a = i_a_oe & i_a;
  assign o_gate_b = i_b_oe & i_b;
  // Shoot-through is counted, not prevented, so the bench can see it
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) o_overlap <= 16'h0;
    else if (o_gate_a && o_gate_b) o_overlap <= o_overlap + 16'h1;
  end
endmodule : cdsd_switch_model
`default_nettype wire

/* File: dv/cdsd_top_tb_top.sv */
/*
  Self-checking bench for the complementary drive block over APB.
  Assumes one wait state per APB transfer and a 40 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module cdsd_top_tb_top;
  logic clk, rstn, psel, pen, pwr, pready, pslverr, cmp, flt_n, a, aoe, b, boe, ga, gb;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [2:0] pwm;
  logic [15:0] ov;
  logic [5:0] dbr, dbf;
  logic ia, ib, o, err_q;
  int fails, check_count, n;

  cdsd_top DUT (.i_clk(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_pwm_outs(pwm), .i_comparator_async_out(cmp),
    .i_fault_input_n(flt_n), .o_drive_output_a(a), .o_drive_output_a_oe(aoe),
    .o_drive_output_b(b), .o_drive_output_b_oe(boe));
  cdsd_switch_model SW (.i_clk(clk), .i_resetn(rstn), .i_a(a), .i_a_oe(aoe), .i_b(b),
    .i_b_oe(boe), .o_gate_a(ga), .o_gate_b(gb), .o_overlap(ov));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Request held through the edge that samples pready high, released right after it
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int k;
    psel <= 1'b1; pwr <= w; paddr <= ad; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      fails++;
      wrap_up();
    end
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0; pen <= 1'b0;
    @(posedge clk);
  endtask : apb

  // Released pin is shown as 0 so a tri-stated value never matters
  task automatic pins(input string nm, input logic [3:0] e);
    @(negedge clk);
    chk(nm, e, {aoe & a, aoe, boe & b, boe});
    @(posedge clk);
  endtask : pins

  task automatic wait_pin(input logic sel_b, output int k, output logic other);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while ((sel_b ? b : a) !== 1'b1 && k < 80);
    other = sel_b ? a : b;
    if ((sel_b ? b : a) !== 1'b1) begin
      fails++;
      wrap_up();
    end
    @(posedge clk);
  endtask : wait_pin

  function automatic logic [1:0] ovr(input logic [1:0] c, input logic inv);
    case (c)
      2'h3: return 2'h3;
      2'h2: return 2'h1;
      2'h1: return 2'h0;
      default: return {inv, 1'b1};
    endcase
  endfunction : ovr

  initial begin
    rstn = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    pwm = 3'h0; cmp = 1'b0; flt_n = 1'b1;
    void'($urandom(51100));
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    apb(1'b0, 8'h00, 32'h0); chk("ctrl_reset", 32'h0, rd_q);
    apb(1'b0, 8'h08, 32'h0); chk("sd_reset", 32'h0, rd_q);
    apb(1'b0, 8'h14, 32'h0); chk("unmapped_err", 1, err_q);
    dbr = 6'($urandom_range(5, 0));
    dbf = 6'($urandom_range(5, 0));
    // Set up with the module off, starting from shutdown
    apb(1'b1, 8'h0c, {26'h0, dbr});
    apb(1'b1, 8'h10, {26'h0, dbf});
    apb(1'b1, 8'h04, 32'he2);
    apb(1'b1, 8'h08, 32'h82);
    apb(1'b1, 8'h00, 32'he0);
    pins("ovr_start", 4'b0111);
    flt_n <= 1'b0;
    apb(1'b1, 8'h08, 32'h02);
    apb(1'b0, 8'h08, 32'h0); chk("clear_refused", 32'h82, rd_q);
    flt_n <= 1'b1;
    apb(1'b1, 8'h08, 32'h02);
    apb(1'b0, 8'h08, 32'h0); chk("clear_taken", 32'h02, rd_q);
    pins("ovr_held", 4'b0111);
    for (int k = 0; k < 4; k++) begin
      pwm[0] <= 1'b1;
      wait_pin(1'b0, n, o);
      chk("rise_delay", 1, n >= dbr + 2 && n <= dbr + 4);
      chk("b_off_at_a_on", 0, o);
      repeat ($urandom_range(4, 1)) @(posedge clk);
      pwm[0] <= 1'b0;
      wait_pin(1'b1, n, o);
      chk("fall_delay", 1, n >= dbf + 2 && n <= dbf + 4);
      chk("a_off_at_b_on", 0, o);
      repeat ($urandom_range(4, 1)) @(posedge clk);
    end
    chk("overlap", 0, ov);
    // Slow tick: five dead-band counts need two to three cycles each
    apb(1'b1, 8'h0c, 32'h5);
    apb(1'b1, 8'h00, 32'he1);
    pwm[0] <= 1'b1;
    wait_pin(1'b0, n, o);
    chk("hf_rise_delay", 1, n >= 12 && n <= 19);
    // Every override code on A, its mirror on B, random polarity
    for (int c = 0; c < 4; c++) begin
      ia = 1'($urandom_range(1, 0));
      ib = 1'($urandom_range(1, 0));
      apb(1'b1, 8'h00, {24'h0, 3'h7, ib, ia, 3'h0});
      apb(1'b1, 8'h04, {24'h0, 2'(3 - c), 2'(c), 4'h2});
      apb(1'b1, 8'h08, 32'h80);
      pins("ovr_code", {ovr(2'(c), ia), ovr(2'(3 - c), ib)});
    end
    apb(1'b1, 8'h08, 32'h44);
    cmp <= 1'b1;
    @(posedge clk);
    pins("cmp_trip", {ovr(2'h3, ia), ovr(2'h0, ib)});
    apb(1'b0, 8'h08, 32'h0); chk("cmp_event", 32'hc4, rd_q);
    cmp <= 1'b0;
    apb(1'b0, 8'h08, 32'h0); chk("auto_clear", 32'h44, rd_q);
    apb(1'b1, 8'h08, 32'hc0);
    apb(1'b0, 8'h08, 32'h0); chk("auto_sw_clear", 32'h40, rd_q);
    apb(1'b1, 8'h08, 32'h00);
    flt_n <= 1'b0;
    cmp <= 1'b1;
    apb(1'b0, 8'h08, 32'h0); chk("sources_off", 32'h0, rd_q);
    flt_n <= 1'b1;
    cmp <= 1'b0;
    apb(1'b1, 8'h00, 32'h0);
    pins("module_off", 4'b0000);
    wrap_up();
  end
endmodule : cdsd_top_tb_top
`default_nettype wire
